/* core/fwc_map.svh */
`ifndef FWC_MAP_SVH
`define FWC_MAP_SVH
// register byte offsets on the control bus
`define FWC_CTL_OFFSET 12'h000
// cache_control field positions
`define FWC_CTL_ON_BIT 0
`define FWC_CTL_WT_BIT 1
`define FWC_CTL_CB_BIT 2
`define FWC_CTL_FLUSH_BIT 3
`define FWC_CTL_RSVD_LO 4
// reset values
`define FWC_CTL_RESET 32'h0000_0000
`define FWC_LRU_RESET 6'h00
// address fields
`define FWC_TAG_LO 10
`define FWC_PHYS_HI 28
`define FWC_IDX_HI 11
`define FWC_IDX_LO 4
`define FWC_WORD_HI 3
`define FWC_WORD_LO 2
`define FWC_SHADOW_ZERO 3'h0
`endif

/* core/fwc_pkg.sv */
`default_nettype none
package fwc_pkg;
    localparam int FWC_WAYS = 4;
    localparam int FWC_SETS = 256;
    typedef logic [21:0] fwc_tag_type;
    typedef logic [7:0] fwc_idx_type;
    typedef logic [1:0] fwc_way_type;
    typedef logic [5:0] fwc_lru_type;
    typedef logic [127:0] fwc_line_type;
    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic [31:0] wdata;
    } fwc_lookup_req_type;
    typedef struct packed {
        logic hit;
        fwc_way_type way;
        fwc_way_type victim;
        logic victim_valid;
        logic victim_dirty;
        fwc_tag_type victim_tag;
        logic [31:0] rdata;
        logic cacheable;
        logic write_through;
    } fwc_lookup_rsp_type;
    typedef struct packed {
        logic [31:0] addr;
        fwc_way_type way;
        fwc_line_type line;
    } fwc_fill_type;
endpackage
`default_nettype wire

/* core/fwc_cache_ctrl.sv */
// Operation
// - valid flag per entry gates hits
// - dirty flag set on write-back writes
// - 22-bit tag of three zero bits and bits 28..10 compared
// - replacement clears top three tag bits
// - power-on clears valid/dirty, manual keeps
// - tags and data never reset
// - fills move whole 16-byte lines
// - index taken from address bits 11..4
// - six history bits per index pick victim
// - listed history patterns replace way 3
// - listed history patterns replace way 2
// - listed history patterns replace way 1
// - listed history patterns replace way 0
// - power-on clears history, manual keeps
// - cache_on bit enables cache use
// - writethrough_sel sets policy for kernel/user zero, three
// - segment1_writeback_sel sets kernel_segment_one policy
// - flush_all clears valid, dirty, history; reads zero
// - bits 31..4 read zero, write zero
// - four ways of 256 entries
`include "fwc_map.svh"
`timescale 1ns/10ps
`default_nettype none
module fwc_cache_ctrl
    import fwc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    input wire logic manual_rst,
    input wire logic lk_valid,
    input wire fwc_lookup_req_type lk_req,
    output logic lk_done,
    output var fwc_lookup_rsp_type lk_rsp,
    input wire logic fill_valid,
    input wire fwc_fill_type fill,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] CTL_RESET_VAL = `FWC_CTL_RESET;
    // control register fields
    logic ctl_on;
    logic ctl_wt;
    logic ctl_cb;
    // address array flags and history, held in flops so reset can clear them
    logic [3:0] vld [FWC_SETS];
    logic [3:0] dirty [FWC_SETS];
    fwc_lru_type lru [FWC_SETS];
    // tag and line storage, no reset port at all
    fwc_tag_type tag_mem [FWC_WAYS][FWC_SETS];
    fwc_line_type data_mem [FWC_WAYS][FWC_SETS];
    // bus write side holding state
    logic aw_have;
    logic w_have;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic wr_map;
    logic flush_req;
    // lookup decode
    fwc_idx_type req_idx;
    fwc_tag_type req_tag;
    logic [1:0] req_word;
    logic req_cacheable;
    logic req_wt;
    logic [3:0] way_hit;
    logic hit_now;
    fwc_way_type hit_way;
    fwc_way_type victim_now;
    fwc_idx_type fill_idx;
    fwc_tag_type fill_tag;
    // victim choice from the pairwise age bits
    function automatic fwc_way_type lru_victim(input fwc_lru_type h);
        fwc_way_type w;
        w = 2'h3;
        if (h[5] && h[4] && h[3]) begin
            w = 2'h0;
        end else if (!h[5] && h[2] && h[1]) begin
            w = 2'h1;
        end else if (!h[4] && !h[2] && h[0]) begin
            w = 2'h2;
        end
        return w;
    endfunction

    // mark a way as most recently used
    function automatic fwc_lru_type lru_touch(input fwc_lru_type h, input fwc_way_type w);
        fwc_lru_type n;
        n = h;
        case (w)
            2'h0: begin
                n[5:3] = 3'h0;
            end
            2'h1: begin
                n[5] = 1'b1;
                n[2:1] = 2'h0;
            end
            2'h2: begin
                n[4] = 1'b1;
                n[2] = 1'b1;
                n[0] = 1'b0;
            end
            default: begin
                n[3] = 1'b1;
                n[1] = 1'b1;
                n[0] = 1'b1;
            end
        endcase
        return n;
    endfunction

    // index and tag; the shadow bits take part in the compare as zeros on both sides
    assign req_idx = lk_req.addr[`FWC_IDX_HI:`FWC_IDX_LO];
    assign req_tag = {`FWC_SHADOW_ZERO, lk_req.addr[`FWC_PHYS_HI:`FWC_TAG_LO]};
    assign req_word = lk_req.addr[`FWC_WORD_HI:`FWC_WORD_LO];
    assign fill_idx = fill.addr[`FWC_IDX_HI:`FWC_IDX_LO];
    assign fill_tag = {`FWC_SHADOW_ZERO, fill.addr[`FWC_PHYS_HI:`FWC_TAG_LO]};

    // region decode: kernel_segment_one and the zero/three segments differ
    always_comb begin
        req_cacheable = 1'b1;
        req_wt = ctl_wt;
        case (lk_req.addr[31:29])
            3'h4: begin
                req_wt = !ctl_cb;
            end
            3'h5, 3'h7: begin
                req_cacheable = 1'b0;
                req_wt = 1'b1;
            end
            default: ;
        endcase
    end

    // per-way tag compare
    for (genvar w = 0; w < FWC_WAYS; w++) begin : g_way
        assign way_hit[w] = vld[req_idx][w] && (tag_mem[w][req_idx] == req_tag);
    end

    // hit encode; a disabled cache never hits
    always_comb begin
        hit_way = 2'h0;
        for (int i = 0; i < FWC_WAYS; i++) begin
            if (way_hit[i]) begin
                hit_way = 2'(i);
            end
        end
        hit_now = ctl_on && req_cacheable && (way_hit != 4'h0);
    end
    assign victim_now = lru_victim(lru[req_idx]);

    // bus write commit
    assign wr_fire = aw_have && w_have && !s_axi_bvalid;
    assign wr_map = ({aw_addr[11:2], 2'h0} == `FWC_CTL_OFFSET);
    assign flush_req = ce && wr_fire && wr_map && w_strb[0] && w_data[`FWC_CTL_FLUSH_BIT];

    // write address and data are taken independently, response after both
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_have <= 1'b0;
                w_have <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // control fields; upper bits are not stored, so writes there are dropped
    always_ff @(posedge clk_sys) begin
        if (srst || (ce && manual_rst)) begin
            ctl_on <= CTL_RESET_VAL[`FWC_CTL_ON_BIT];
            ctl_wt <= CTL_RESET_VAL[`FWC_CTL_WT_BIT];
            ctl_cb <= CTL_RESET_VAL[`FWC_CTL_CB_BIT];
        end else if (ce && wr_fire && wr_map && w_strb[0]) begin
            ctl_on <= w_data[`FWC_CTL_ON_BIT];
            ctl_wt <= w_data[`FWC_CTL_WT_BIT];
            ctl_cb <= w_data[`FWC_CTL_CB_BIT];
        end
    end

    // one read at a time; flush bit and upper bits read as zero
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= RESP_SLVERR;
                if ({s_axi_araddr[11:2], 2'h0} == `FWC_CTL_OFFSET) begin
                    s_axi_rresp <= RESP_OKAY;
                    s_axi_rdata[`FWC_CTL_ON_BIT] <= ctl_on;
                    s_axi_rdata[`FWC_CTL_WT_BIT] <= ctl_wt;
                    s_axi_rdata[`FWC_CTL_CB_BIT] <= ctl_cb;
                end
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // valid and dirty flags; manual reset is deliberately ignored here
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            for (int i = 0; i < FWC_SETS; i++) begin
                vld[i] <= 4'h0;
                dirty[i] <= 4'h0;
            end
        end else if (ce) begin
            if (flush_req) begin
                for (int i = 0; i < FWC_SETS; i++) begin
                    vld[i] <= 4'h0;
                    dirty[i] <= 4'h0;
                end
            end else if (lk_valid && lk_req.write && hit_now && !req_wt) begin
                dirty[req_idx][hit_way] <= 1'b1;
            end
            // a fill in the flush cycle survives: set beats clear
            if (fill_valid) begin
                vld[fill_idx][fill.way] <= 1'b1;
                dirty[fill_idx][fill.way] <= 1'b0;
            end
        end
    end

    // replacement history per index
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            for (int i = 0; i < FWC_SETS; i++) begin
                lru[i] <= `FWC_LRU_RESET;
            end
        end else if (ce) begin
            if (flush_req) begin
                for (int i = 0; i < FWC_SETS; i++) begin
                    lru[i] <= `FWC_LRU_RESET;
                end
            end else if (lk_valid && hit_now) begin
                lru[req_idx] <= lru_touch(lru[req_idx], hit_way);
            end
            // same index hit and fill: the fill's update is kept
            if (fill_valid) begin
                lru[fill_idx] <= lru_touch(lru[fill_idx], fill.way);
            end
        end
    end

    // tag and line storage; no reset branch so contents survive any reset
    always_ff @(posedge clk_sys) begin
        if (ce) begin
            if (lk_valid && lk_req.write && hit_now) begin
                data_mem[hit_way][req_idx][{req_word, 5'h00} +: 32] <= lk_req.wdata;
            end
            if (fill_valid) begin
                tag_mem[fill.way][fill_idx] <= fill_tag;
                data_mem[fill.way][fill_idx] <= fill.line;
            end
        end
    end

    // lookup answer one cycle later, with the victim for a miss
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            lk_done <= 1'b0;
            lk_rsp <= '0;
        end else if (ce) begin
            lk_done <= lk_valid;
            if (lk_valid) begin
                lk_rsp.hit <= hit_now;
                lk_rsp.way <= hit_way;
                lk_rsp.victim <= victim_now;
                lk_rsp.victim_valid <= vld[req_idx][victim_now];
                lk_rsp.victim_dirty <= dirty[req_idx][victim_now];
                lk_rsp.victim_tag <= tag_mem[victim_now][req_idx];
                lk_rsp.rdata <= data_mem[hit_way][req_idx][{req_word, 5'h00} +: 32];
                lk_rsp.cacheable <= ctl_on && req_cacheable;
                lk_rsp.write_through <= req_wt;
            end
        end
    end

    // helper state for the checks below
    fwc_idx_type h_idx, h_fidx;
    fwc_way_type h_way, h_fway;
    always_ff @(posedge clk_sys) begin
        if (ce) begin
            h_idx <= req_idx;
            h_way <= hit_way;
            h_fidx <= fill_idx;
            h_fway <= fill.way;
        end
    end

    a_off_no_hit: assert property (@(posedge clk_sys) disable iff (srst)
        ce && lk_valid && !ctl_on |=> !lk_rsp.hit)
        else $error("hit reported while cache disabled");
    a_victim_way3: assert property (@(posedge clk_sys) disable iff (srst)
        ce && lk_valid && (lru[req_idx] inside {6'h00, 6'h04, 6'h14, 6'h20, 6'h30, 6'h34})
        |=> lk_rsp.victim == 2'h3)
        else $error("wrong victim, expected way 3");
    a_victim_way2: assert property (@(posedge clk_sys) disable iff (srst)
        ce && lk_valid && (lru[req_idx] inside {6'h01, 6'h03, 6'h0b, 6'h21, 6'h29, 6'h2b})
        |=> lk_rsp.victim == 2'h2)
        else $error("wrong victim, expected way 2");
    a_victim_way1: assert property (@(posedge clk_sys) disable iff (srst)
        ce && lk_valid && (lru[req_idx] inside {6'h06, 6'h07, 6'h0f, 6'h16, 6'h1e, 6'h1f})
        |=> lk_rsp.victim == 2'h1)
        else $error("wrong victim, expected way 1");
    a_victim_way0: assert property (@(posedge clk_sys) disable iff (srst)
        ce && lk_valid && (lru[req_idx] inside {6'h38, 6'h39, 6'h3b, 6'h3c, 6'h3e, 6'h3f})
        |=> lk_rsp.victim == 2'h0)
        else $error("wrong victim, expected way 0");
    a_fill_shadow: assert property (@(posedge clk_sys) disable iff (srst)
        ce && fill_valid |=> tag_mem[h_fway][h_fidx][21:19] == 3'h0)
        else $error("shadow bits of filled tag not cleared");
    a_fill_hits: assert property (@(posedge clk_sys) disable iff (srst)
        ce && fill_valid && !flush_req |=> vld[h_fidx][h_fway])
        else $error("filled entry not valid");
    a_dirty_wb: assert property (@(posedge clk_sys) disable iff (srst)
        ce && lk_valid && lk_req.write && hit_now && !req_wt && !flush_req && !fill_valid
        |=> dirty[h_idx][h_way])
        else $error("write-back hit did not mark entry dirty");
    a_flush_clear: assert property (@(posedge clk_sys) disable iff (srst)
        flush_req && !fill_valid |=> vld[8'hff] == 4'h0 && lru[8'hff] == 6'h00)
        else $error("flush left flags or history set");
    a_manual_keep: assert property (@(posedge clk_sys) disable iff (srst)
        ce && manual_rst && !fill_valid && !lk_valid && !flush_req
        |=> $stable(vld[8'hff]) && $stable(lru[8'hff]) && !ctl_on)
        else $error("manual reset disturbed flags or kept cache on");
    a_rsvd_zero: assert property (@(posedge clk_sys) disable iff (srst)
        s_axi_rvalid |-> s_axi_rdata[31:`FWC_CTL_RSVD_LO] == 28'h0 &&
        !s_axi_rdata[`FWC_CTL_FLUSH_BIT])
        else $error("reserved or flush bits read non-zero");
    a_hit_valid: assert property (@(posedge clk_sys) disable iff (srst)
        ce && lk_valid && vld[req_idx] == 4'h0 |=> lk_done && !lk_rsp.hit)
        else $error("hit on an index with no valid way");

    c_read_hit: cover property (@(posedge clk_sys) disable iff (srst)
        ce && lk_valid && !lk_req.write && hit_now);
    c_write_hit_wb: cover property (@(posedge clk_sys) disable iff (srst)
        ce && lk_valid && lk_req.write && hit_now && !req_wt);
    c_miss_dirty_victim: cover property (@(posedge clk_sys) disable iff (srst)
        lk_done && !lk_rsp.hit && lk_rsp.victim_dirty);
    c_flush: cover property (@(posedge clk_sys) disable iff (srst) flush_req);
endmodule
`default_nettype wire

/* bench/fwc_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
// memory side of the cache: returns one whole line a cycle after each request
module fwc_mem_model
    import fwc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic req,
    input wire logic [31:0] req_addr,
    input wire fwc_way_type req_way,
    output logic fill_valid,
    output var fwc_fill_type fill
);
    // each word carries its own address, so a wrong word select shows up
    always_ff @(posedge clk_sys) begin
        fill_valid <= req & ~srst;
        if (srst) begin
            fill <= '0;
        end else if (req) begin
            fill.addr <= req_addr;
            fill.way <= req_way;
            for (int w = 0; w < 4; w++) begin
                fill.line[w*32 +: 32] <= {req_addr[31:4], 2'(w), 2'b01};
            end
        end else begin
            // an idle bus keeps toggling so stale data is never taken for a line
            fill.addr <= ~fill.addr;
            fill.line <= ~fill.line;
        end
    end
endmodule
`default_nettype wire

/* bench/tb_four_way_cache_array_control.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module tb_four_way_cache_array_control
    import fwc_pkg::*;
;
    logic clk_sys = 0, srst = 1, manual_rst = 0, lk_valid = 0, lk_done, fill_valid;
    fwc_lookup_req_type lk_req = '0;
    fwc_lookup_rsp_type lk_rsp, r;
    fwc_fill_type fill;
    logic mreq = 0;
    logic [31:0] maddr = '0, d;
    fwc_way_type mway = '0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rs, ws;
    int n_errors = 0, num_checks = 0;
    // free-running 125 MHz system clock
    always #4 clk_sys = ~clk_sys;
    fwc_cache_ctrl dut (.clk_sys(clk_sys), .srst(srst), .ce(1'b1), .manual_rst(manual_rst),
        .lk_valid(lk_valid), .lk_req(lk_req), .lk_done(lk_done), .lk_rsp(lk_rsp),
        .fill_valid(fill_valid), .fill(fill), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    fwc_mem_model mem (.clk_sys(clk_sys), .srst(srst), .req(mreq), .req_addr(maddr),
        .req_way(mway), .fill_valid(fill_valid), .fill(fill));
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic timed_out();
        n_errors++;
        $display("Error at %0t: bus wait ran out", $time);
        conclude();
    endtask
    // write: address and data offered together, each released when taken
    task automatic axw(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
        for (int i = 0; i < 50; i++) begin
            @(posedge clk_sys);
            if (awvalid && awready) begin
                awvalid <= 0;
                awaddr <= ~awaddr;
            end
            if (wvalid && wready) begin
                wvalid <= 0;
                wdata <= ~wdata;
            end
            if (bvalid) begin
                ws = bresp;
                bready <= 0;
                return;
            end
        end
        timed_out();
    endtask
    task automatic axr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] e);
        @(posedge clk_sys);
        araddr <= a; arvalid <= 1; rready <= 1;
        for (int i = 0; i < 50; i++) begin
            @(posedge clk_sys);
            if (arvalid && arready) begin
                arvalid <= 0;
                araddr <= ~araddr;
            end
            if (rvalid) begin
                v = rdata;
                e = rresp;
                rready <= 0;
                return;
            end
        end
        timed_out();
    endtask
    // one lookup; the answer is looked at in the cycle after it is taken
    task automatic lk(input logic [31:0] a, input logic wr = 0, input logic [31:0] v = '0);
        @(posedge clk_sys);
        lk_valid <= 1; lk_req <= '{addr: a, write: wr, wdata: v};
        @(posedge clk_sys);
        lk_valid <= 0; lk_req <= ~lk_req;
        #1;
        `CHK(lk_done, 1'b1)
        r = lk_rsp;
    endtask
    task automatic fl(input logic [31:0] a, input fwc_way_type w);
        @(posedge clk_sys);
        mreq <= 1; maddr <= a; mway <= w;
        @(posedge clk_sys);
        mreq <= 0;
        repeat (2) @(posedge clk_sys);
    endtask
    function automatic logic [31:0] ad(input int i);
        return 32'h2000_0ff4 + (32'(i + 1) << 12); // top bits 001, index 0xff
    endfunction
    function automatic logic [31:0] wexp(input logic [31:0] a);
        return {a[31:4], a[3:2], 2'b01};
    endfunction
    // main sequence
    initial begin
        repeat (6) @(posedge clk_sys);
        srst <= 0;
        axr(12'h000, d, rs);
        `CHK({rs, d}, 34'h0)
        axr(12'h010, d, rs);
        `CHK({rs, d}, {2'b10, 32'h0})
        axw(12'h010, 32'h0000_0000);
        `CHK(ws, 2'b10)
        axw(12'h000, 32'h0000_0007);
        `CHK(ws, 2'b00)
        axr(12'h000, d, rs);
        `CHK(d, 32'h0000_0007)
        axw(12'h000, 32'h0000_0001);
        // fill all four ways of the last index in history order
        for (int i = 0; i < 4; i++) begin
            lk(ad(i));
            `CHK({r.hit, r.victim_valid}, 2'b00)
            `CHK(r.victim, 2'(3 - i))
            fl(ad(i), 2'(3 - i));
            lk(ad(i));
            `CHK({r.hit, r.way}, {1'b1, 2'(3 - i)})
            `CHK(r.rdata, wexp(ad(i)))
            lk(ad(i) + 32'h8);
            `CHK(r.rdata, wexp(ad(i) + 32'h8))
        end
        lk(ad(0) ^ 32'h4000_0000);
        `CHK({r.hit, r.way}, 3'b111)
        lk(ad(0) ^ 32'h1000_0000);
        `CHK({r.hit, r.victim, r.victim_valid}, 4'b0101)
        d = ad(1);
        `CHK(r.victim_tag, {3'b000, d[28:10]})
        lk(ad(0) ^ 32'h10);
        `CHK({r.hit, r.victim_valid}, 2'b00)
        // write-back write, then age that way back to the replacement choice
        lk(ad(3), 1, 32'hcafe_0001);
        `CHK({r.hit, r.write_through}, 2'b10)
        lk(ad(3));
        `CHK(r.rdata, 32'hcafe_0001)
        for (int i = 0; i < 3; i++) lk(ad(i));
        lk(ad(0) ^ 32'h1000_0000);
        `CHK({r.victim, r.victim_dirty}, 3'b001)
        axw(12'h000, 32'h0000_0003);
        lk(ad(2), 1, 32'h1);
        `CHK({r.hit, r.write_through}, 2'b11)
        lk(32'h8000_0ff4);
        `CHK({r.cacheable, r.write_through}, 2'b11)
        axw(12'h000, 32'h0000_0007);
        lk(32'h8000_0ff4);
        `CHK(r.write_through, 1'b0)
        lk(32'ha000_0ff4);
        `CHK({r.cacheable, r.hit}, 2'b00)
        // manual reset clears control only
        @(posedge clk_sys) manual_rst <= 1;
        @(posedge clk_sys) manual_rst <= 0;
        axr(12'h000, d, rs);
        `CHK(d, 32'h0)
        lk(ad(0));
        `CHK(r.hit, 1'b0)
        axw(12'h000, 32'h0000_0001);
        lk(ad(0));
        `CHK({r.hit, r.way}, 3'b111)
        lk(ad(0) ^ 32'h1000_0000);
        `CHK(r.victim, 2'd0)
        // flush drops every entry and the history
        axw(12'h000, 32'h0000_0009);
        axr(12'h000, d, rs);
        `CHK(d, 32'h0000_0001)
        lk(ad(1));
        `CHK({r.hit, r.victim, r.victim_valid, r.victim_dirty}, 5'b01100)
        // power-on reset in mid-run
        fl(ad(0), 2'd0);
        lk(ad(0));
        `CHK(r.hit, 1'b1)
        @(posedge clk_sys) srst <= 1;
        repeat (2) @(posedge clk_sys);
        srst <= 0;
        axr(12'h000, d, rs);
        `CHK(d, 32'h0)
        axw(12'h000, 32'h0000_0001);
        lk(ad(0));
        `CHK({r.hit, r.victim, r.victim_valid}, 4'b0110)
        conclude();
    end
endmodule
`default_nettype wire
